// >>> dv/artc_conv_model.sv
// Converter core stand-in: one sensor conversion per go pulse.
// Assumes the bench pulses go on the system clock.
`timescale 1ns/100ps
`default_nettype none
module artc_conv_model (
  input wire logic clk_sys_in,
  input wire logic go_in,
  output logic [4:0] mux_out,
  output logic trk_out,
  output logic cnv_out,
  output logic req_out
);
  logic [2:0] ph_q = 3'h0;
  // Phase counter wraps to idle after eight steps
  always @(posedge clk_sys_in) begin
    if (go_in || ph_q != 3'h0) ph_q <= ph_q + 3'h1;
  end
  // ground channel first
  // Idles on a port channel, steps through ground, then holds the sensor
  assign mux_out = (ph_q == 3'h0) ? 5'h00 :
                   (ph_q == 3'h1) ? 5'h1f : 5'h18;
  assign trk_out = ph_q == 3'h2 || ph_q == 3'h3;
  assign cnv_out = ph_q[2];
  assign req_out = ph_q[2];
endmodule // artc_conv_model
`default_nettype wire

// >>> dv/artc_ref_ctrl_checker.sv
// Port-level checks on the reference control block.
// Assumes it is bound into the reference control module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module artc_ref_ctrl_checker (
  input wire logic clk_sys_in, rst_in, sfr_wr_in, sfr_rd_in,
  input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
  input wire logic [9:0] trim_value_in,
  input wire logic [4:0] conv_mux_sel_in,
  input wire logic conv_tracking_in, conv_converting_in,
  input wire logic conv_hs_ref_req_in, hs_ref_enable_out,
  input wire logic [1:0] vref_route_out,
  input wire logic pref_enable_out, pref_pin_connect_out, gnd_analog_ground_pin_out,
  input wire logic sensor_enable_out, sensor_to_mux_out, gnd_internal_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_wr; sfr_wr_in && sfr_addr_in == 8'hd1; endsequence
  sequence s_rd(x); sfr_rd_in && sfr_addr_in == x; endsequence
  a_ctrl_write: assert property (s_wr |-> ##2
    vref_route_out == $past(sfr_wdata_in[4:3], 2) &&
    gnd_analog_ground_pin_out == $past(sfr_wdata_in[5], 2) &&
    pref_enable_out == $past(sfr_wdata_in[0], 2) &&
    sensor_enable_out == $past(sfr_wdata_in[2], 2)) else $error("ctrl write");
  a_offset_high: assert property (s_rd(8'h86) |=>
    sfr_rdata_out == trim_value_in[9:2]) else $error("offset high");
  a_offset_low: assert property (s_rd(8'h85) |=>
    sfr_rdata_out == {trim_value_in[1:0], 6'h00}) else $error("offset low");
  a_ctrl_zeros: assert property (s_rd(8'hd1) |=>
    (sfr_rdata_out & 8'hc2) == 8'h00) else $error("ctrl zeros");
  a_hs_gate: assert property (hs_ref_enable_out ==
    (vref_route_out == 2'h3 && $past(conv_hs_ref_req_in)))
    else $error("hs gate");
  a_sensor_path: assert property (sensor_to_mux_out ==
    (sensor_enable_out && $past(conv_mux_sel_in) == 5'h18))
    else $error("sensor path");
  a_gnd_internal: assert property (gnd_internal_out ==
    ($past(conv_mux_sel_in == 5'h18 && conv_tracking_in) ||
    (vref_route_out == 2'h3 && $past(conv_converting_in))))
    else $error("internal gnd");
  a_pref_pair: assert property (
    pref_pin_connect_out == pref_enable_out) else $error("pref pair");
  a_rdata_hold: assert property (!sfr_rd_in |=>
    $stable(sfr_rdata_out)) else $error("rdata hold");
endmodule // artc_ref_ctrl_checker
bind artc_ref_ctrl artc_ref_ctrl_checker u_chk (.*);
`default_nettype wire

// >>> dv/artc_ref_ctrl_tb_top.sv
// Bench for the reference control block; converter model on far side.
// Assumes a static trim value and a converter that runs on the same clock.
`timescale 1ns/100ps
`default_nettype none
module artc_ref_ctrl_tb_top;
  logic clk_sys_in = 0, rst_in = 1, wr = 0, rd = 0, go = 0;
  logic [7:0] a = 0, d = 0;
  int fails = 0, comparisons = 0, cyc = 0, n;
  localparam logic [9:0] TRIM = 10'h2b5;
  wire [7:0] q;
  wire [4:0] mx;
  wire [1:0] vr;
  wire trk, cnv, req, hs, ga;
  wire pe, pp, se, stm, gi;
  initial forever #25 clk_sys_in = ~clk_sys_in;
  artc_conv_model cm (.clk_sys_in, .go_in(go), .mux_out(mx),
    .trk_out(trk), .cnv_out(cnv), .req_out(req));
  artc_ref_ctrl uut (.clk_sys_in, .rst_in, .sfr_addr_in(a),
    .sfr_wdata_in(d), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(q),
    .trim_value_in(TRIM), .conv_mux_sel_in(mx), .conv_tracking_in(trk),
    .conv_converting_in(cnv), .conv_hs_ref_req_in(req),
    .vref_route_out(vr), .pref_enable_out(pe), .pref_pin_connect_out(pp),
    .hs_ref_enable_out(hs), .sensor_enable_out(se),
    .sensor_to_mux_out(stm), .gnd_analog_ground_pin_out(ga), .gnd_internal_out(gi));
  task chk(string s, logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // One strobe cycle, then settle one edge
  task bus(logic w, logic [7:0] x, y);
    @(posedge clk_sys_in);
    a <= x; d <= y; wr <= w; rd <= !w;
    @(posedge clk_sys_in);
    wr <= 0; rd <= 0;
    @(posedge clk_sys_in);
    #1;
  endtask
  task rdc(logic [7:0] x, e, string s);
    bus(0, x, 8'h00);
    chk(s, e, q);
  endtask
  task t_offset;
    rdc(8'h86, TRIM[9:2], "offh");
    rdc(8'h85, {TRIM[1:0], 6'h00}, "offl");
    bus(1, 8'h85, 8'hff);
    bus(1, 8'h86, 8'h00);
    rdc(8'h86, TRIM[9:2], "offh wr");
    rdc(8'h85, {TRIM[1:0], 6'h00}, "offl wr");
    rdc(8'h40, 8'h00, "unmapped");
    $display("offset test done");
  endtask
  task t_ctrl;
    for (int s = 0; s < 5; s++) begin
      n = {2'h3, s[0], s[1:0], s[1], 1'b1, s[2]};
      bus(1, 8'hd1, n[7:0]);
      chk("route", {6'h00, s[1:0]}, {6'h00, vr});
      chk("gnd", s[0], ga);
      chk("pref en", s[2], pe);
      chk("pref pin", s[2], pp);
      chk("sensor en", s[1], se);
      rdc(8'hd1, n[7:0] & 8'h3d, "ctrl");
    end
    $display("ctrl test done");
  endtask
  task t_conv(logic [7:0] c, e, f, g);
    int nh, ns, ng;
    bus(1, 8'hd1, c);
    go <= 1;
    @(posedge clk_sys_in);
    go <= 0;
    nh = 0;
    ns = 0;
    ng = 0;
    repeat (12) @(negedge clk_sys_in) begin
      nh += hs;
      ns += stm;
      ng += gi;
    end
    chk("hs cycles", e, nh[7:0]);
    chk("sensor path", f, ns[7:0]);
    chk("int gnd", g, ng[7:0]);
    $display("conv test done");
  endtask
  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_in) if (++cyc == 3000) begin
    fails++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 0;
    @(posedge clk_sys_in);
    rdc(8'hd1, 8'h18, "ctrl rst");
    t_offset;
    t_ctrl;
    t_conv(8'h1c, 8'h04, 8'h06, 8'h06);
    t_conv(8'h04, 8'h00, 8'h06, 8'h02);
    t_conv(8'h18, 8'h04, 8'h00, 8'h06);
    wrap_up;
  end
endmodule // artc_ref_ctrl_tb_top
`default_nettype wire

// >>> inc/artc_consts.vh
// Constants for the reference and temperature sensor control block.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
`ifndef ARTC_CONSTS_VH
`define ARTC_CONSTS_VH

// ==========================================================
// Register addresses
`define ARTC_ADDR_OFFSET_LOW 8'h85
`define ARTC_ADDR_OFFSET_HIGH 8'h86
`define ARTC_ADDR_REF_CTRL 8'hd1

// ==========================================================
// Reference control fields
`define ARTC_BIT_GND_SEL 5
`define ARTC_BIT_REFSEL_HI 4
`define ARTC_BIT_REFSEL_LO 3
`define ARTC_BIT_SENSOR_EN 2
`define ARTC_BIT_PREF_OE 0
`define ARTC_REF_CTRL_RESET 8'h18
`define ARTC_REF_CTRL_MASK 8'h3d

// ==========================================================
// Reference select codes
`define ARTC_REFSEL_EXT 2'h0
`define ARTC_REFSEL_VDD 2'h1
`define ARTC_REFSEL_DIG 2'h2
`define ARTC_REFSEL_HS 2'h3

// ==========================================================
// Offset field layout
`define ARTC_OFFS_HI_MSB 9
`define ARTC_OFFS_HI_LSB 2
`define ARTC_OFFS_LO_MSB 1
`define ARTC_OFFS_LO_LSB 0
`define ARTC_OFFL_ZERO 6'h00
`define ARTC_BYTE_ZERO 8'h00

// Converter mux code of the sensor channel (arbitrary default)
`define ARTC_MUX_TEMP 5'h18

`endif

// >>> rtl/artc_offset_store.v
// Holds the factory temperature offset; captured once after reset release.
// Assumes the trim value input is a static fuse level on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "artc_consts.vh"

module artc_offset_store #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Fuse value and stored copy
  input wire [WIDTH-1:0] trim_value_in,
  output reg [WIDTH-1:0] offset_value_out
);

  reg loaded_q;

  // ==========================================================
  // Capture
  // per-device load
  // Loaded by the clock after reset, never from the reset itself
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      loaded_q <= 1'b0;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      offset_value_out <= trim_value_in;
    end
  end

endmodule // artc_offset_store
`default_nettype wire

// >>> rtl/artc_ref_ctrl.v
// Reference, ground and temperature sensor control with offset registers.
// Assumes a synchronous SFR bus: one-cycle write strobe, registered read.
`timescale 1ns/100ps
`default_nettype none
`include "artc_consts.vh"

module artc_ref_ctrl #(
  parameter OFFS_W = 10
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Register bus
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  output reg [7:0] sfr_rdata_out,
  // Factory trim
  input wire [OFFS_W-1:0] trim_value_in,
  // Converter core status
  input wire [4:0] conv_mux_sel_in,
  input wire conv_tracking_in,
  input wire conv_converting_in,
  input wire conv_hs_ref_req_in,
  // Analog control
  output reg [1:0] vref_route_out,
  output reg pref_enable_out,
  output reg pref_pin_connect_out,
  output reg hs_ref_enable_out,
  output reg sensor_enable_out,
  output reg sensor_to_mux_out,
  output reg gnd_analog_ground_pin_out,
  output reg gnd_internal_out
);

  // Control register and its next value
  reg [7:0] ref_ctrl_q;
  reg [7:0] ref_ctrl_d;
  // Stored factory offset
  wire [OFFS_W-1:0] offset_value;
  // Decoded views of the control register, the converter mux select and the bus
  wire [1:0] reference_select;
  wire hs_selected;
  wire sensor_sampled;
  wire ctrl_wr_hit;
  // Read data before its register
  reg [7:0] rdata_d;

  // ==========================================================
  // Factory offset copy
  // The copy is taken one clock after reset release; a read in that very
  // clock would return an unloaded value, so software waits one clock
  artc_offset_store #(
    .WIDTH(OFFS_W)
  ) u_offs (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .trim_value_in(trim_value_in),
    .offset_value_out(offset_value)
  );

  // ==========================================================
  // Field and channel decode
  // select field view
  assign reference_select =
    ref_ctrl_q[`ARTC_BIT_REFSEL_HI:`ARTC_BIT_REFSEL_LO];
  // Shared by the on-demand enable and the ground override
  assign hs_selected = (reference_select == `ARTC_REFSEL_HS);
  // sensor on positive input
  // The sensor reaches the converter only as a single-ended positive input
  assign sensor_sampled = (conv_mux_sel_in == `ARTC_MUX_TEMP);

  // ==========================================================
  // Bus decode
  // no offset write strobe
  // Only the control register decodes a write; the offset addresses have
  // no write strobe at all, so the factory value cannot be disturbed
  assign ctrl_wr_hit = sfr_wr_in && (sfr_addr_in == `ARTC_ADDR_REF_CTRL);

  // ==========================================================
  // Control register
  // control register write
  // Unused bits are masked so they always read zero; a write to them is
  // accepted but leaves nothing behind
  always @* begin
    ref_ctrl_d = ref_ctrl_q;
    if (ctrl_wr_hit) begin
      ref_ctrl_d = sfr_wdata_in & `ARTC_REF_CTRL_MASK;
    end
  end

  // Register update; the reset value selects the high-speed reference
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ref_ctrl_q <= `ARTC_REF_CTRL_RESET;
    end else begin
      ref_ctrl_q <= ref_ctrl_d;
    end
  end

  // ==========================================================
  // Read mux
  // offsets have no write path
  always @* begin
    rdata_d = `ARTC_BYTE_ZERO;
    case (sfr_addr_in)
      `ARTC_ADDR_OFFSET_HIGH: begin
        rdata_d = offset_value[`ARTC_OFFS_HI_MSB:`ARTC_OFFS_HI_LSB];
      end
      `ARTC_ADDR_OFFSET_LOW: begin
        rdata_d = {offset_value[`ARTC_OFFS_LO_MSB:`ARTC_OFFS_LO_LSB],
                   `ARTC_OFFL_ZERO};
      end
      `ARTC_ADDR_REF_CTRL: begin
        rdata_d = ref_ctrl_q;
      end
      default: begin
        rdata_d = `ARTC_BYTE_ZERO;
      end
    endcase
  end

  // Read data is held between reads so software sees a stable byte
  // Reads of unmapped addresses load zero
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      sfr_rdata_out <= `ARTC_BYTE_ZERO;
    end else if (sfr_rd_in) begin
      sfr_rdata_out <= rdata_d;
    end
  end

  // ==========================================================
  // Analog steering
  // Every steering output is its own flop so the analog side never sees
  // a decode glitch; the price is one clock of lag after each change

  // route reference
  // The route follows the select field alone; 00 carries the pin, which
  // holds the precision reference only while its output enable is set
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      vref_route_out <= `ARTC_REFSEL_HS;
    end else begin
      vref_route_out <= reference_select;
    end
  end

  // precision reference enable
  // Enable alone drives the pin; it is the selected ref only under 00
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      pref_enable_out <= 1'b0;
      pref_pin_connect_out <= 1'b0;
    end else begin
      pref_enable_out <= ref_ctrl_q[`ARTC_BIT_PREF_OE];
      pref_pin_connect_out <= ref_ctrl_q[`ARTC_BIT_PREF_OE];
    end
  end

  // high-speed on demand
  // Kept off between conversions; the core's request is a same-clock level
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      hs_ref_enable_out <= 1'b0;
    end else begin
      hs_ref_enable_out <= hs_selected && conv_hs_ref_req_in;
    end
  end

  // sensor on or off
  // The path to the mux closes only for the sensor channel, so a disabled
  // or unselected sensor never loads the converter input
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      sensor_enable_out <= 1'b0;
      sensor_to_mux_out <= 1'b0;
    end else begin
      sensor_enable_out <= ref_ctrl_q[`ARTC_BIT_SENSOR_EN];
      sensor_to_mux_out <= ref_ctrl_q[`ARTC_BIT_SENSOR_EN] &&
                           sensor_sampled;
    end
  end

  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      gnd_analog_ground_pin_out <= 1'b0;
    end else begin
      gnd_analog_ground_pin_out <= ref_ctrl_q[`ARTC_BIT_GND_SEL];
    end
  end

  // internal ground override
  // Overrides the ground select bit; the analog side gives this priority
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      gnd_internal_out <= 1'b0;
    end else begin
      gnd_internal_out <= (sensor_sampled && conv_tracking_in) ||
                          (hs_selected && conv_converting_in);
    end
  end

endmodule // artc_ref_ctrl
`default_nettype wire
